// ===== hw/clk_tb_defs.vh
// constants for the clock distribution, time base and watchdog block
// assumes it is included by bare name from the design file
`ifndef CLK_TB_DEFS_VH
`define CLK_TB_DEFS_VH

// combined prescaler and stabilisation counter preset, 13 bits
`define PRE_PRESET 7'h78
`define STAB_PRESET 6'h00
`define PRE_LAST 7'h7f
`define STAB_LAST 6'h3f

// system clock select encodings
`define SEL_DIV2 2'b00
`define SEL_DIV4 2'b01
`define SEL_DIV64 2'b10
`define SEL_SUB4 2'b11
`define SEL_RESET 2'b10

// prescaler tap widths (log2 of divide)
`define TAP_DIV2 4'd1
`define TAP_DIV4 4'd2
`define TAP_DIV64 4'd6
`define TAP_DIV128 4'd7

// sub clock divide-by-4 for the system clock
`define SUB_DIV_LAST 2'h3

// time base
`define TB_PRESET 14'h0078
`define TB_STARTUP_BIT 13
`define TB_LCD64_BIT 5
`define TB_LCD128_BIT 6

// watchdog rate select encodings and their tap widths
`define RATE_RESET 2'b11
`define RATE_TAP_00 4'd7
`define RATE_TAP_01 4'd12
`define RATE_TAP_10 4'd13
`define RATE_TAP_11 4'd14
`define WDOG_LAST 3'h7

`endif

// ===== hw/clock_timebase_ctrl.v
// clock distribution, time base and watchdog of a small microcontroller
// assumes oscillator levels arrive on pins far slower than mclk_i
// assumes stop, wait and register writes come as mclk_i pulses
`timescale 1ns/1ps
`default_nettype none
`include "clk_tb_defs.vh"

module clock_timebase_ctrl (
  input wire mclk_i,
  input wire rst_b_i,
  input wire main_osc_i,
  input wire sub_osc_i,
  input wire ext_reset_b_i,
  input wire power_down_wake_input_i,
  input wire ext_interrupt_a_i,
  input wire ext_interrupt_b_i,
  input wire keyboard_wakeup_i,
  input wire rtc_irq_i,
  input wire any_irq_i,
  input wire stop_req_i,
  input wire wait_req_i,
  input wire sysclk_select_wr_i,
  input wire sysclk_select_hi_i,
  input wire sysclk_select_lo_i,
  input wire main_clk_enable_wr_i,
  input wire main_clk_enable_i,
  input wire timebase_clk_select_wr_i,
  input wire timebase_clk_select_i,
  input wire lcd_clk_select_wr_i,
  input wire lcd_clk_select_i,
  input wire rate_select_wr_i,
  input wire rate_select_hi_i,
  input wire rate_select_lo_i,
  input wire watchdog_enable_wr_i,
  input wire watchdog_enable_i,
  input wire watchdog_clear_wr_i,
  input wire watchdog_clear_data_i,
  output reg sysclk_select_hi_o,
  output reg sysclk_select_lo_o,
  output reg main_clk_enable_o,
  output reg timebase_clk_select_o,
  output reg lcd_clk_select_o,
  output reg rate_select_hi_o,
  output reg rate_select_lo_o,
  output reg watchdog_enable_o,
  output reg main_clk_ready_flag_o,
  output reg timebase_startup_flag_o,
  output reg main_osc_run_o,
  output reg periph_tick_o,
  output reg cpu_tick_o,
  output reg lcd_clock_o,
  output reg internal_reset_o,
  output reg watchdog_reset_o,
  output reg stop_mode_o,
  output reg wait_mode_o
);

  localparam ST_RUN = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_STOP = 2'd2;
  localparam ST_RECOV = 2'd3;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // low lg bits of a count all ones: the tap wraps on the next edge
  function tap_hit;
    input [13:0] cnt;
    input [3:0] lg;
    reg [13:0] mask;
    begin
      mask = (14'h0001 << lg) - 14'h0001;
      tap_hit = &(cnt | ~mask);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: osc a, osc b, reset, four wake pins

  reg [6:0] sy1_q;
  reg [6:0] sy2_q;
  reg [1:0] osc_prev_q;

  // two flops, then a third for oscillator edge detection
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sy1_q <= 7'h04;
      sy2_q <= 7'h04;
      osc_prev_q <= 2'h0;
    end else begin
      sy1_q <= {keyboard_wakeup_i, ext_interrupt_b_i, ext_interrupt_a_i,
                power_down_wake_input_i, ext_reset_b_i, sub_osc_i, main_osc_i};
      sy2_q <= sy1_q;
      osc_prev_q <= sy2_q[1:0];
    end
  end

  reg osc_run_q;
  reg [1:0] st_q;
  reg wd_to;
  wire ext_rst = ~sy2_q[2];
  wire any_rst = ext_rst | wd_to;
  wire wake = |sy2_q[6:3] | rtc_irq_i;
  wire main_edge = sy2_q[0] & ~osc_prev_q[0] & osc_run_q;
  wire sub_edge = sy2_q[1] & ~osc_prev_q[1];
  wire stop_entry = (st_q == ST_RUN) & stop_req_i & ~any_rst;

  ////////////////////////////////////////////////////////////////////////
  // control bits written by the cpu

  reg [1:0] sel_q;
  reg mce_q;
  reg tbsel_q;
  reg tbsel_done_q;
  reg lcdsel_q;
  reg [1:0] rate_q;
  reg wden_q;
  reg wden_done_q;

  // every reset source restores these values
  always @(posedge mclk_i) begin
    if (!rst_b_i || any_rst) begin
      sel_q <= `SEL_RESET;
      mce_q <= 1'b1;
      tbsel_q <= 1'b0;
      tbsel_done_q <= 1'b0;
      lcdsel_q <= 1'b0;
      rate_q <= `RATE_RESET;
      wden_q <= 1'b0;
      wden_done_q <= 1'b0;
    end else begin
      if (sysclk_select_wr_i)
        sel_q <= {sysclk_select_hi_i, sysclk_select_lo_i};
      if (main_clk_enable_wr_i)
        mce_q <= main_clk_enable_i;
      if (timebase_clk_select_wr_i && !tbsel_done_q) begin
        tbsel_q <= timebase_clk_select_i;
        tbsel_done_q <= 1'b1;
      end
      if (lcd_clk_select_wr_i)
        lcdsel_q <= lcd_clk_select_i;
      if (rate_select_wr_i)
        rate_q <= {rate_select_hi_i, rate_select_lo_i};
      if (watchdog_enable_wr_i && !wden_done_q) begin
        wden_q <= watchdog_enable_i;
        wden_done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler, stabilisation counter and ready flag

  reg [6:0] pre_q;
  reg [5:0] stab_q;
  reg ready_q;
  wire pre_wrap = main_edge & (pre_q == `PRE_LAST);
  wire stab_ovf = pre_wrap & ~ready_q & (stab_q == `STAB_LAST);

  // counters halt with the oscillator; enable clear presets them
  always @(posedge mclk_i) begin
    if (!rst_b_i || !mce_q) begin
      pre_q <= `PRE_PRESET;
      stab_q <= `STAB_PRESET;
      ready_q <= 1'b0;
    end else begin
      if (main_edge)
        pre_q <= pre_q + 7'h01;
      if (stop_entry)
        stab_q <= `STAB_PRESET;
      else if (pre_wrap && !ready_q)
        stab_q <= stab_q + 6'h01;
      // overflow wins over a stop entry in the same cycle
      ready_q <= stab_ovf | (ready_q & ~stop_entry);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power mode sequencer

  reg rcv_rst_q;

  // recovery waits for the ready flag; sub clock exits resume at once
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      st_q <= ST_RECOV;
      rcv_rst_q <= 1'b1;
    end else if (any_rst) begin
      // no wait only when main osc was running and stable
      st_q <= ready_q ? ST_RUN : ST_RECOV;
      rcv_rst_q <= ~ready_q;
    end else begin
      case (st_q)
        ST_RUN: begin
          if (stop_req_i)
            st_q <= ST_STOP;
          else if (wait_req_i)
            st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (any_irq_i)
            st_q <= ST_RUN;
        end
        ST_STOP: begin
          if (wake) begin
            rcv_rst_q <= 1'b0;
            if (sel_q == `SEL_SUB4)
              st_q <= ST_RUN;
            else
              st_q <= ST_RECOV;
          end
        end
        ST_RECOV: begin
          if (ready_q) begin
            st_q <= ST_RUN;
            rcv_rst_q <= 1'b0;
          end
        end
        default: st_q <= ST_RUN;
      endcase
    end
  end

  // main oscillator runs when enabled and not in stop
  always @(posedge mclk_i) begin
    if (!rst_b_i)
      osc_run_q <= 1'b1;
    else
      osc_run_q <= mce_q & ~(st_q == ST_STOP) & ~stop_entry;
  end

  ////////////////////////////////////////////////////////////////////////
  // system clock selection

  reg [1:0] sub_div_q;
  reg [3:0] sys_tap;
  reg sys_tick;

  // sub oscillator divide-by-4 for the system clock
  always @(posedge mclk_i) begin
    if (!rst_b_i)
      sub_div_q <= 2'h0;
    else if (sub_edge)
      sub_div_q <= sub_div_q + 2'h1;
  end

  // pick the selected system clock tick
  always @* begin
    case (sel_q)
      `SEL_DIV2: sys_tap = `TAP_DIV2;
      `SEL_DIV4: sys_tap = `TAP_DIV4;
      default: sys_tap = `TAP_DIV64;
    endcase
    if (sel_q == `SEL_SUB4)
      sys_tick = sub_edge & (sub_div_q == `SUB_DIV_LAST);
    else
      sys_tick = main_edge & tap_hit({7'h00, pre_q}, sys_tap);
  end

  wire int_rst = any_rst | (st_q == ST_RECOV & rcv_rst_q);
  wire clk_live = (st_q == ST_RUN) | (st_q == ST_WAIT);

  // stop disconnects both paths; wait stops only the cpu
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      periph_tick_o <= 1'b0;
      cpu_tick_o <= 1'b0;
    end else begin
      periph_tick_o <= sys_tick & clk_live & ~int_rst;
      cpu_tick_o <= sys_tick & (st_q == ST_RUN) & ~int_rst;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // time base, startup flag and lcd clock

  reg [13:0] tb_q;
  reg timebase_startup_flag_q;
  wire tb_tick = tbsel_q ? (main_edge & tap_hit({7'h00, pre_q}, `TAP_DIV128))
                         : sub_edge;

  // preset at power-on only; flag sticks until power-down
  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      tb_q <= `TB_PRESET;
      timebase_startup_flag_q <= 1'b0;
    end else begin
      if (tb_tick)
        tb_q <= tb_q + 14'h0001;
      timebase_startup_flag_q <= timebase_startup_flag_q | tb_q[`TB_STARTUP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog

  reg [3:0] rate_tap;
  reg [2:0] wd_cnt_q;

  // rate select to time base tap width
  always @* begin
    case (rate_q)
      2'b00: rate_tap = `RATE_TAP_00;
      2'b01: rate_tap = `RATE_TAP_01;
      2'b10: rate_tap = `RATE_TAP_10;
      default: rate_tap = `RATE_TAP_11;
    endcase
  end

  wire wd_tick = tb_tick & tap_hit(tb_q, rate_tap);
  wire wd_clr = watchdog_clear_wr_i & ~watchdog_clear_data_i;

  // timeout on the eighth rate tick; timeout beats a clear
  always @* begin
    wd_to = wden_q & wd_tick & (wd_cnt_q == `WDOG_LAST);
  end

  // divider counts rate ticks while enabled
  always @(posedge mclk_i) begin
    if (!rst_b_i || !wden_q || wd_to)
      wd_cnt_q <= 3'h0;
    else if (wd_clr)
      wd_cnt_q <= 3'h0;
    else if (wd_tick)
      wd_cnt_q <= wd_cnt_q + 3'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs

  always @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sysclk_select_hi_o <= 1'b1;
      sysclk_select_lo_o <= 1'b0;
      main_clk_enable_o <= 1'b1;
      timebase_clk_select_o <= 1'b0;
      lcd_clk_select_o <= 1'b0;
      rate_select_hi_o <= 1'b1;
      rate_select_lo_o <= 1'b1;
      watchdog_enable_o <= 1'b0;
      main_clk_ready_flag_o <= 1'b0;
      timebase_startup_flag_o <= 1'b0;
      main_osc_run_o <= 1'b1;
      lcd_clock_o <= 1'b0;
      internal_reset_o <= 1'b1;
      watchdog_reset_o <= 1'b0;
      stop_mode_o <= 1'b0;
      wait_mode_o <= 1'b0;
    end else begin
      sysclk_select_hi_o <= sel_q[1];
      sysclk_select_lo_o <= sel_q[0];
      main_clk_enable_o <= mce_q;
      timebase_clk_select_o <= tbsel_q;
      lcd_clk_select_o <= lcdsel_q;
      rate_select_hi_o <= rate_q[1];
      rate_select_lo_o <= rate_q[0];
      watchdog_enable_o <= wden_q;
      main_clk_ready_flag_o <= ready_q;
      timebase_startup_flag_o <= timebase_startup_flag_q;
      main_osc_run_o <= osc_run_q;
      lcd_clock_o <= lcdsel_q ? tb_q[`TB_LCD128_BIT] : tb_q[`TB_LCD64_BIT];
      internal_reset_o <= int_rst;
      watchdog_reset_o <= wd_to;
      stop_mode_o <= st_q == ST_STOP;
      wait_mode_o <= st_q == ST_WAIT;
    end
  end

endmodule

`default_nettype wire

// ===== test/osc_model.sv
// oscillator pair feeding the clock block's oscillator pins
// assumes run_i is the block's pad enable for the main oscillator
`timescale 1ns/1ps
`default_nettype none
module osc_model #(parameter int HALF_NS = 100) (
  input wire logic run_i,
  output logic main_o,
  output logic sub_o
);
  // sub runs free from power-up, offset from the system clock
  initial begin
    sub_o = 1'h0;
    #7;
    forever #(HALF_NS) sub_o = ~sub_o;
  end
  // main stands low while the pad enable is off
  initial begin
    main_o = 1'h0;
    forever #(HALF_NS) main_o = (run_i === 1'h1) ? ~main_o : 1'h0;
  end
endmodule
`default_nettype wire

// ===== test/clock_timebase_ctrl_assertions.sv
// port checker for the clock distribution, time base and watchdog block
// assumes one clock domain and the synchronous power-on reset
`timescale 1ns/1ps
`default_nettype none
module clock_timebase_ctrl_checker (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic stop_req_i,
  input wire logic sysclk_select_hi_o,
  input wire logic sysclk_select_lo_o,
  input wire logic main_clk_enable_o,
  input wire logic timebase_clk_select_o,
  input wire logic lcd_clk_select_o,
  input wire logic rate_select_hi_o,
  input wire logic rate_select_lo_o,
  input wire logic watchdog_enable_o,
  input wire logic main_clk_ready_flag_o,
  input wire logic timebase_startup_flag_o,
  input wire logic main_osc_run_o,
  input wire logic periph_tick_o,
  input wire logic cpu_tick_o,
  input wire logic internal_reset_o,
  input wire logic watchdog_reset_o,
  input wire logic stop_mode_o,
  input wire logic wait_mode_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);
  // control bits gathered in port order
  wire [7:0] ctl = {sysclk_select_hi_o, sysclk_select_lo_o, main_clk_enable_o, timebase_clk_select_o,
    lcd_clk_select_o, rate_select_hi_o, rate_select_lo_o, watchdog_enable_o};
  ////////////////////////////////////////////////////////////////////////
  a_reset_ctl_values:
  assert property ($rose(rst_b_i) |-> internal_reset_o && ctl == 8'ha6) else $error("bad reset values");
  a_stop_entry_seq:
  assert property (stop_req_i && !stop_mode_o && !wait_mode_o && !internal_reset_o |=> ##1
    (!main_osc_run_o && stop_mode_o) ##[0:2] !main_clk_ready_flag_o) else $error("stop entry wrong");
  a_stop_quiet_ticks:
  assert property (stop_mode_o && $past(stop_mode_o) |-> !periph_tick_o && !cpu_tick_o) else $error("tick in stop");
  a_wait_cpu_halt:
  assert property (wait_mode_o && $past(wait_mode_o) |-> !cpu_tick_o) else $error("cpu tick in wait");
  a_wdog_clears_ctl:
  assert property (watchdog_reset_o |-> ##[1:4] (!watchdog_enable_o && rate_select_hi_o && rate_select_lo_o))
    else $error("timeout kept control bits");
  a_ready_before_run:
  assert property ($fell(internal_reset_o) |-> main_clk_ready_flag_o) else $error("reset left before ready");
  a_startup_flag_sticky:
  assert property (timebase_startup_flag_o |=> timebase_startup_flag_o) else $error("startup flag cleared");
  a_half_tick_spacing:
  assert property (periph_tick_o && !sysclk_select_hi_o && !sysclk_select_lo_o |=> (!periph_tick_o) [*8])
    else $error("ticks too close");
  a_osc_off_enable:
  assert property (!main_clk_enable_o && !$past(main_clk_enable_o) |-> !main_osc_run_o) else $error("osc runs");
endmodule
bind clock_timebase_ctrl clock_timebase_ctrl_checker clock_timebase_ctrl_checker_i (.mclk_i, .rst_b_i, .stop_req_i,
  .sysclk_select_hi_o, .sysclk_select_lo_o, .main_clk_enable_o, .timebase_clk_select_o, .lcd_clk_select_o,
  .rate_select_hi_o, .rate_select_lo_o, .watchdog_enable_o, .main_clk_ready_flag_o, .timebase_startup_flag_o,
  .main_osc_run_o, .periph_tick_o, .cpu_tick_o, .internal_reset_o, .watchdog_reset_o, .stop_mode_o, .wait_mode_o);
`default_nettype wire

// ===== test/clock_timebase_ctrl_test.sv
// self-checking bench for the clock distribution, time base and watchdog block
// assumes osc_model for the oscillators and the bound checker
`timescale 1ns/1ps
`default_nettype none
module clock_timebase_ctrl_test;
  localparam int MP = 8; // oscillator period in mclk cycles
  logic mclk_i, rst_b_i, ext_b, any_irq, lcd_d;
  logic [4:0] wk;
  logic [8:0] st;
  logic [1:0] d;
  int errors, n_tests;
  wire [7:0] ctl;
  wire main_osc, sub_osc, ready, timebase_startup_flag, osc_run, ptick, ctick, lcdc, irst, wdr, stopm, waitm;
  clock_timebase_ctrl clock_timebase_ctrl_i (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .main_osc_i(main_osc), .sub_osc_i(sub_osc), .ext_reset_b_i(ext_b),
    .power_down_wake_input_i(wk[0]), .ext_interrupt_a_i(wk[1]), .ext_interrupt_b_i(wk[2]),
    .keyboard_wakeup_i(wk[3]), .rtc_irq_i(wk[4]), .any_irq_i(any_irq), .stop_req_i(st[7]), .wait_req_i(st[8]),
    .sysclk_select_wr_i(st[0]), .sysclk_select_hi_i(d[1]), .sysclk_select_lo_i(d[0]),
    .main_clk_enable_wr_i(st[1]), .main_clk_enable_i(d[0]), .timebase_clk_select_wr_i(st[2]),
    .timebase_clk_select_i(d[0]), .lcd_clk_select_wr_i(st[3]), .lcd_clk_select_i(d[0]),
    .rate_select_wr_i(st[4]), .rate_select_hi_i(d[1]), .rate_select_lo_i(d[0]),
    .watchdog_enable_wr_i(st[5]), .watchdog_enable_i(d[0]), .watchdog_clear_wr_i(st[6]),
    .watchdog_clear_data_i(d[0]), .sysclk_select_hi_o(ctl[7]), .sysclk_select_lo_o(ctl[6]),
    .main_clk_enable_o(ctl[5]), .timebase_clk_select_o(ctl[4]), .lcd_clk_select_o(ctl[3]),
    .rate_select_hi_o(ctl[2]), .rate_select_lo_o(ctl[1]), .watchdog_enable_o(ctl[0]),
    .main_clk_ready_flag_o(ready), .timebase_startup_flag_o(timebase_startup_flag), .main_osc_run_o(osc_run),
    .periph_tick_o(ptick), .cpu_tick_o(ctick), .lcd_clock_o(lcdc), .internal_reset_o(irst),
    .watchdog_reset_o(wdr), .stop_mode_o(stopm), .wait_mode_o(waitm));
  osc_model osc_model_i (.run_i(osc_run), .main_o(main_osc), .sub_o(sub_osc));
  ////////////////////////////////////////////////////////////////////////
  // clock and lcd edge detect
  initial begin
    mclk_i = 1'h0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) lcd_d <= lcdc;
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected system tick period per select code
  function automatic int per(input int s);
    return (s == 0) ? 2 * MP : (s == 2) ? 64 * MP : 4 * MP;
  endfunction
  function automatic logic sig(input int w);
    case (w)
      0: return ptick;
      1: return lcdc & ~lcd_d;
      2: return ctick;
      3: return irst;
      5: return stopm;
      6: return wdr;
      default: return timebase_startup_flag;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] got);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      errors++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // one-cycle strobe with data, then settle
  task automatic wr(input int b, input logic [1:0] v);
    st[b] = 1'h1;
    d = v;
    @(negedge mclk_i);
    st = 9'h0;
    repeat (3) @(negedge mclk_i);
  endtask
  task automatic wt(input int w, input logic v, input int lim, output int n);
    n = 0;
    while (sig(w) !== v && n < lim) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task automatic gap(input int w, output int n);
    wt(w, 1'h1, 5000, n);
    @(negedge mclk_i);
    wt(w, 1'h1, 5000, n);
    n++;
  endtask
  task automatic stop_test;
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (99000) @(posedge mclk_i);
    errors++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int n, k, o;
    logic [15:0] r;
    r = 16'h9f48;
    {rst_b_i, any_irq, wk, st, d} = 18'h0;
    ext_b = 1'h1;
    repeat (2) @(negedge mclk_i);
    rst_b_i = 1'h1;
    @(negedge mclk_i);
    chk("ctl", 8'ha6, 8'ha6, ctl);
    wt(3, 1'h0, 70000, n);
    chk("recov", 8072 * MP - 16, 8072 * MP + 40, n);
    wt(4, 1'h1, 2000, k);
    chk("timebase_startup_flag", 8072 * MP - 16, 8072 * MP + 40, n + k);
    for (int s = 0; s < 4; s++) begin
      wr(0, s[1:0]);
      gap(0, n);
      chk("ptick", per(s) - 1, per(s) + 1, n);
      gap(2, n);
      chk("ctick", per(s) - 1, per(s) + 1, n);
    end
    for (int i = 0; i < 2; i++) begin
      r = nxt(r);
      wr(3, {1'h0, r[0] ^ i[0]});
      k = (r[0] ^ i[0]) ? 128 * MP : 64 * MP;
      gap(1, n);
      chk("lcd", k - 1, k + 1, n);
    end
    wr(8, 2'h0);
    chk("waitm", 1, 1, waitm);
    gap(0, n);
    chk("wait_p", per(3) - 1, per(3) + 1, n);
    wt(2, 1'h1, 200, n);
    chk("wait_c", 200, 200, n);
    any_irq = 1'h1;
    wt(2, 1'h1, 200, n);
    any_irq = 1'h0;
    chk("wake_c", 0, 40, n);
    chk("wait_x", 0, 0, waitm);
    wr(4, 2'h0);
    wr(5, 2'h1);
    wr(5, 2'h0);
    chk("wde", 1, 1, ctl[0]);
    for (int i = 0; i < 3; i++) begin
      r = nxt(r);
      repeat (2000 + r[9:0]) @(negedge mclk_i);
      wr(6, 2'h0);
    end
    wr(6, 2'h1);
    wt(6, 1'h1, 9000, n);
    chk("wd_t", 6 * 128 * MP, 8 * 128 * MP + 20, n + 8);
    repeat (20) @(negedge mclk_i);
    chk("wd_ctl", 8'ha6, 8'ha6, ctl);
    chk("wd_irst", 0, 0, irst);
    wr(0, 2'h0);
    ext_b = 1'h0;
    repeat (4) @(negedge mclk_i);
    ext_b = 1'h1;
    repeat (20) @(negedge mclk_i);
    chk("ext_ctl", 8'ha6, 8'ha6, ctl);
    chk("ext_irst", 0, 0, irst);
    chk("timebase_startup_flag_k", 1, 1, timebase_startup_flag);
    wr(2, 2'h1);
    wr(2, 2'h0);
    chk("tb_once", 1, 1, ctl[4]);
    wr(0, 2'h3);
    r = nxt(r);
    o = r % 5;
    for (int i = 0; i < 6; i++) begin
      if (i == 5) wr(1, 2'h0);
      wr(7, 2'h0);
      chk("stop", 1, 1, stopm);
      chk("osc_s", 0, 0, osc_run);
      chk("rdy_s", 0, 0, ready);
      wk[(i + o) % 5] = 1'h1;
      wt(5, 1'h0, 20, n);
      wk = 5'h0;
      chk("exit", 0, 19, n);
      wt(0, 1'h1, 60, n);
      chk("resume", 0, 40, n);
      chk("osc_x", i < 5, i < 5, osc_run);
      chk("irst_x", 0, 0, irst);
    end
    wr(1, 2'h1);
    chk("osc_re", 1, 1, osc_run);
    // stop on the main clock: exit restarts it, ticks held for recovery
    wr(0, 2'h2);
    wr(7, 2'h0);
    chk("stop_m", 1, 1, stopm);
    wk[0] = 1'h1;
    wt(5, 1'h0, 20, n);
    wk = 5'h0;
    chk("exit_m", 0, 19, n);
    wt(0, 1'h1, 600, n);
    chk("hold_m", 600, 600, n);
    chk("osc_m", 1, 1, osc_run);
    stop_test();
  end
endmodule
`default_nettype wire
